// *** fcr_pkg.sv ***
package fcr_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int ADDR_W  = 22;
  localparam int BANK_BIT = 21;
  localparam int PAGE_W  = 17;
  localparam int LINE_W  = 128;
  localparam int RAW_W   = 144;
  localparam int NBUF    = 4;
  localparam int TIM_W   = 4;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_TIM0      = 8'h04;
  localparam logic [7:0] REG_TIM1      = 8'h08;
  localparam logic [7:0] REG_RGN_BASE  = 8'h0c;
  localparam logic [7:0] REG_RGN_LIMIT = 8'h10;
  localparam logic [7:0] REG_RGN_TIM   = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_ECC_ADDR  = 8'h1c;

  // CTRL field positions
  localparam int CTRL_BUF_EN   = 0;
  localparam int CTRL_PF_EN    = 1;
  localparam int CTRL_ABORT_EN = 2;
  localparam int CTRL_STALL_NT = 3;
  localparam int CTRL_ABORT_NT = 4;
  // STATUS field positions
  localparam int ST_SBE   = 0;
  localparam int ST_DBE   = 1;
  localparam int ST_STALL = 2;
  localparam int ST_ABORT = 3;
  localparam int ST_BUSY  = 4;
  // Region timing enable bit
  localparam int RGN_EN   = 4;

  // ---------------------------------------------------------------------
  // Reset values: a working setup with no software help
  // ---------------------------------------------------------------------
  localparam logic [4:0]       CTRL_RST   = 5'h03;
  localparam logic [TIM_W-1:0] TIM0_RST   = 4'h1;
  localparam logic [TIM_W-1:0] TIM1_RST   = 4'h1;
  localparam logic [TIM_W-1:0] RGN_TIM_RST = 4'h1;

  typedef enum logic [2:0] {
    FCR_IDLE, FCR_ARB, FCR_ACC, FCR_FILL, FCR_WR, FCR_ERR1, FCR_ERR2
  } fcr_state_t;

endpackage : fcr_pkg

// *** fcr_ecc72.sv ***
`timescale 1ns/1ns
`default_nettype none

// Single-error-correct, double-error-detect check of one 64-bit word
// against its 8 check bits (7 position bits plus overall parity).
module fcr_ecc72 (
  input  wire logic [63:0] data,
  input  wire logic [7:0]  chk,
  output logic      [63:0] cdata,
  output logic             sbe,
  output logic             dbe
);

  function automatic logic [6:0] ham_pos(input int idx);
    int         n;
    logic [6:0] p;
    n = 0;
    p = 7'h00;
    for (int k = 3; k < 72; k++) begin
      if ((k & (k - 1)) != 0) begin
        if (n == idx) begin
          p = 7'(k);
        end
        n++;
      end
    end
    return p;
  endfunction : ham_pos

  logic [6:0] syn;
  logic       par;

  always_comb begin
    syn = chk[6:0];
    for (int i = 0; i < 64; i++) begin
      if (data[i]) begin
        syn = syn ^ ham_pos(i);
      end
    end
    par   = ^{data, chk};
    cdata = data;
    // Odd overall parity means one flipped bit; fix it if it is data
    for (int i = 0; i < 64; i++) begin
      if (par && syn == ham_pos(i)) begin
        cdata[i] = ~data[i];
      end
    end
    sbe = par;
    dbe = !par && (syn != 7'h00);
  end

endmodule : fcr_ecc72

`default_nettype wire

// *** fcr_ctrl.sv ***
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module fcr_ctrl
  import fcr_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // AHB slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [63:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [63:0]       hrdata,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Array side
  output logic      [1:0]        arr_rd_en,
  output logic      [PAGE_W-1:0] arr_rd_page,
  input  wire logic [RAW_W-1:0]  arr_rdata0,
  input  wire logic [RAW_W-1:0]  arr_rdata1,
  output logic      [1:0]        arr_wr_en,
  output logic      [20:3]       arr_wr_addr,
  output logic      [63:0]       arr_wr_data,
  output logic                   arr_wr_hi,
  input  wire logic [1:0]        arr_busy,
  output logic      [1:0]        arr_abort,
  // Event notices
  output logic                   stall_note,
  output logic                   abort_note,
  output logic                   ecc_sbe,
  output logic                   ecc_dbe
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  fcr_state_t        state;
  logic [ADDR_W-1:0] cur_addr;
  logic              cur_pf;
  logic [TIM_W-1:0]  cnt;
  logic              stalled;
  logic              pend_vld;
  logic [ADDR_W-1:0] pend_addr;
  logic              pend_write;
  logic [2:0]        pend_size;
  logic              pf_pend;
  logic [PAGE_W-1:0] pf_page;
  logic [RAW_W-1:0]  raw;

  logic [LINE_W-1:0] buf_data [NBUF];
  logic [PAGE_W-1:0] buf_tag  [NBUF];
  logic [NBUF-1:0]   buf_vld;
  logic [1:0]        buf_age  [NBUF];
  logic [LINE_W-1:0] hold_data;
  logic [PAGE_W-1:0] hold_tag;
  logic              hold_vld;

  logic [4:0]        ctrl;
  logic [TIM_W-1:0]  tim0;
  logic [TIM_W-1:0]  tim1;
  logic [PAGE_W-1:0] rgn_base;
  logic [PAGE_W-1:0] rgn_limit;
  logic [4:0]        rgn_tim;
  logic [3:0]        sticky;
  logic [ADDR_W-1:0] ecc_addr;

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  function automatic logic read_ok(input logic [2:0] sz,
                                   input logic [2:0] a);
    logic [3:0] span;
    span = 4'({2'b00, a[1:0]}) + (4'h1 << sz);
    if (sz == 3'd3) begin
      return a == 3'd0;
    end
    return (sz < 3'd3) && (span <= 4'h4);
  endfunction : read_ok

  function automatic logic [63:0] half(input logic [LINE_W-1:0] line,
                                       input logic sel);
    return sel ? line[127:64] : line[63:0];
  endfunction : half

  // -----------------------------------------------------------------------
  // Request decode
  // -----------------------------------------------------------------------
  logic              take;
  logic              can_go;
  logic              go;
  logic [ADDR_W-1:0] r_addr;
  logic              r_write;
  logic [2:0]        r_size;
  logic [PAGE_W-1:0] r_page;
  logic              r_bank;
  logic              hit0;
  logic [1:0]        hit_slot;
  logic              hit1;
  logic              buf_en;
  logic              pf_en;

  assign buf_en = ctrl[CTRL_BUF_EN];
  assign pf_en  = ctrl[CTRL_PF_EN];
  assign take   = hsel && hready && htrans[1];
  assign can_go = (state == FCR_IDLE) || (state == FCR_WR)
                  || (state == FCR_ERR2);
  assign go      = can_go && (take || pend_vld);
  assign r_addr  = take ? haddr[ADDR_W-1:0] : pend_addr;
  assign r_write = take ? hwrite : pend_write;
  assign r_size  = take ? hsize : pend_size;
  assign r_page  = r_addr[20:4];
  assign r_bank  = r_addr[BANK_BIT];

  always_comb begin
    hit0     = 1'b0;
    hit_slot = 2'd0;
    for (int i = 0; i < NBUF; i++) begin
      if (buf_en && buf_vld[i] && buf_tag[i] == r_page) begin
        hit0     = 1'b1;
        hit_slot = 2'(i);
      end
    end
  end
  assign hit1 = buf_en && hold_vld && hold_tag == r_page;

  logic r_hit;
  logic r_bad_wr;
  assign r_hit    = r_bank ? hit1 : hit0;
  assign r_bad_wr = r_write && !(r_size == 3'd2 && r_addr[1:0] == 2'b00);
  logic r_bad_rd;
  assign r_bad_rd = !r_write && !read_ok(r_size, r_addr[2:0]);

  // Wait count: a matching region overrides the bank's own timing
  logic              cur_bank;
  logic [PAGE_W-1:0] cur_page;
  logic [TIM_W-1:0]  acc_cycles;
  logic              in_rgn;
  assign cur_bank = cur_addr[BANK_BIT];
  assign cur_page = cur_addr[20:4];
  assign in_rgn   = rgn_tim[RGN_EN] && cur_page >= rgn_base
                    && cur_page <= rgn_limit;
  always_comb begin
    if (in_rgn) begin
      acc_cycles = rgn_tim[TIM_W-1:0];
    end else begin
      acc_cycles = cur_bank ? tim1 : tim0;
    end
  end

  // -----------------------------------------------------------------------
  // ECC on the captured line
  // -----------------------------------------------------------------------
  logic [63:0] cor_lo;
  logic [63:0] cor_hi;
  logic [1:0]  sbe_w;
  logic [1:0]  dbe_w;
  logic        fill;

  fcr_ecc72 u_ecc_lo (
    .data  (raw[63:0]),
    .chk   (raw[135:128]),
    .cdata (cor_lo),
    .sbe   (sbe_w[0]),
    .dbe   (dbe_w[0])
  );
  fcr_ecc72 u_ecc_hi (
    .data  (raw[127:64]),
    .chk   (raw[143:136]),
    .cdata (cor_hi),
    .sbe   (sbe_w[1]),
    .dbe   (dbe_w[1])
  );
  assign fill = (state == FCR_FILL);

  // -----------------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= FCR_IDLE;
      cur_addr   <= '0;
      cur_pf     <= 1'b0;
      cnt        <= '0;
      stalled    <= 1'b0;
      pend_vld   <= 1'b0;
      pend_addr  <= '0;
      pend_write <= 1'b0;
      pend_size  <= 3'h0;
      pf_pend    <= 1'b0;
      pf_page    <= '0;
      raw        <= '0;
    end else begin
      if (take && !can_go) begin
        pend_vld   <= 1'b1;
        pend_addr  <= haddr[ADDR_W-1:0];
        pend_write <= hwrite;
        pend_size  <= hsize;
      end else if (go) begin
        pend_vld <= 1'b0;
      end
      case (state)
        FCR_IDLE, FCR_WR, FCR_ERR2: begin
          stalled <= 1'b0;
          if (go) begin
            cur_addr <= r_addr;
            cur_pf   <= 1'b0;
            if (r_bad_wr || r_bad_rd) begin
              state <= FCR_ERR1;
            end else if (r_write) begin
              state <= FCR_WR;
            end else if (r_hit) begin
              state <= FCR_IDLE;
            end else begin
              state <= FCR_ARB;
            end
          end else if (pf_pend && state == FCR_IDLE) begin
            cur_addr <= {1'b0, pf_page, 4'h0};
            cur_pf   <= 1'b1;
            pf_pend  <= 1'b0;
            state    <= FCR_ARB;
          end else begin
            state <= FCR_IDLE;
          end
        end
        FCR_ARB: begin
          // One arbitration cycle, longer for a demand access while the bank is busy
          cnt <= (acc_cycles == '0) ? TIM_W'(1) : acc_cycles;
          if (arr_busy[cur_bank]) begin
            stalled <= 1'b1;
            if (cur_pf) begin
              state <= FCR_IDLE;
            end
          end else if (acc_cycles == '0) begin
            // Zero timing skips the access wait for slow clocks
            raw   <= cur_bank ? arr_rdata1 : arr_rdata0;
            state <= FCR_FILL;
          end else begin
            state <= FCR_ACC;
          end
        end
        FCR_ACC: begin
          cnt <= cnt - TIM_W'(1);
          if (cnt == TIM_W'(1)) begin
            raw   <= cur_bank ? arr_rdata1 : arr_rdata0;
            state <= FCR_FILL;
          end
        end
        FCR_FILL: begin
          state <= FCR_IDLE;
          // Fetch the next code page while the bus is quiet
          if (!cur_bank && !cur_pf && pf_en && buf_en) begin
            pf_pend <= 1'b1;
            pf_page <= cur_page + PAGE_W'(1);
          end
        end
        FCR_ERR1: begin
          state <= FCR_ERR2;
        end
        default: begin
          state <= FCR_IDLE;
        end
      endcase
      if (|arr_busy) begin
        pf_pend <= 1'b0;
      end
    end
  end

  // Bus handshake: never ready in the first cycle of a miss
  assign hreadyout = ((state == FCR_IDLE) && !pend_vld)
                     || (state == FCR_WR) || (state == FCR_ERR2);
  assign hresp     = (state == FCR_ERR1) || (state == FCR_ERR2);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 64'h0;
    end else if (go && !r_write && r_hit) begin
      hrdata <= r_bank ? half(hold_data, r_addr[3])
                       : half(buf_data[hit_slot], r_addr[3]);
    end else if (fill && !cur_pf) begin
      hrdata <= cur_addr[3] ? cor_hi : cor_lo;
    end
  end

  // -----------------------------------------------------------------------
  // Array strobes
  // -----------------------------------------------------------------------
  logic rd_go;
  assign rd_go = ((state == FCR_ACC) && cnt == acc_cycles)
                 || ((state == FCR_ARB) && !arr_busy[cur_bank]
                     && acc_cycles == '0);
  assign arr_rd_en[0] = rd_go && !cur_bank;
  assign arr_rd_en[1] = rd_go && cur_bank;
  assign arr_rd_page  = cur_page;

  logic abort_req;
  assign abort_req = (state == FCR_ARB) && arr_busy[cur_bank] && !stalled
                     && !cur_pf && ctrl[CTRL_ABORT_EN];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      arr_wr_en   <= 2'b00;
      arr_wr_addr <= '0;
      arr_wr_data <= 64'h0;
      arr_wr_hi   <= 1'b0;
      arr_abort   <= 2'b00;
      stall_note  <= 1'b0;
      abort_note  <= 1'b0;
      ecc_sbe     <= 1'b0;
      ecc_dbe     <= 1'b0;
    end else begin
      arr_wr_en <= 2'b00;
      if (state == FCR_WR) begin
        arr_wr_en[cur_bank] <= 1'b1;
        arr_wr_addr         <= cur_addr[20:3];
        arr_wr_data         <= hwdata;
        arr_wr_hi           <= cur_addr[2];
      end
      arr_abort <= 2'b00;
      if (abort_req) begin
        arr_abort[cur_bank] <= 1'b1;
      end
      stall_note <= (state == FCR_ARB) && arr_busy[cur_bank] && !stalled
                    && !cur_pf && ctrl[CTRL_STALL_NT];
      abort_note <= abort_req && ctrl[CTRL_ABORT_NT];
      ecc_sbe    <= fill && (|sbe_w);
      ecc_dbe    <= fill && (|dbe_w);
    end
  end

  // -----------------------------------------------------------------------
  // Page buffers and holding register
  // -----------------------------------------------------------------------
  logic [1:0] victim;
  logic       touch;
  logic [1:0] touch_slot;
  always_comb begin
    victim = 2'd0;
    for (int i = 0; i < NBUF; i++) begin
      if (buf_age[i] == 2'd3) begin
        victim = 2'(i);
      end
    end
  end
  assign touch      = (go && !r_write && r_hit && !r_bank)
                      || (fill && !cur_bank);
  assign touch_slot = fill ? victim : hit_slot;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_vld <= '0;
      for (int i = 0; i < NBUF; i++) begin
        buf_age[i]  <= 2'(i);
        buf_tag[i]  <= '0;
        buf_data[i] <= '0;
      end
    end else begin
      if (fill && !cur_bank) begin
        buf_data[victim] <= {cor_hi, cor_lo};
        buf_tag[victim]  <= cur_page;
        buf_vld[victim]  <= 1'b1;
      end
      if (touch) begin
        for (int i = 0; i < NBUF; i++) begin
          if (buf_age[i] < buf_age[touch_slot]) begin
            buf_age[i] <= buf_age[i] + 2'd1;
          end
        end
        buf_age[touch_slot] <= 2'd0;
      end
      if ((state == FCR_WR && !cur_bank) || arr_busy[0]) begin
        buf_vld <= '0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_vld  <= 1'b0;
      hold_tag  <= '0;
      hold_data <= '0;
    end else begin
      if (fill && cur_bank) begin
        hold_data <= {cor_hi, cor_lo};
        hold_tag  <= cur_page;
        hold_vld  <= 1'b1;
      end
      if ((state == FCR_WR && cur_bank) || arr_busy[1]) begin
        hold_vld <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl      <= CTRL_RST;
      tim0      <= TIM0_RST;
      tim1      <= TIM1_RST;
      rgn_base  <= '0;
      rgn_limit <= '0;
      rgn_tim   <= {1'b0, RGN_TIM_RST};
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CTRL:      ctrl      <= reg_wdata[4:0];
        REG_TIM0:      tim0      <= reg_wdata[TIM_W-1:0];
        REG_TIM1:      tim1      <= reg_wdata[TIM_W-1:0];
        REG_RGN_BASE:  rgn_base  <= reg_wdata[20:4];
        REG_RGN_LIMIT: rgn_limit <= reg_wdata[20:4];
        REG_RGN_TIM:   rgn_tim   <= reg_wdata[4:0];
        default: ;
      endcase
    end
  end

  // Sticky flags: a new event beats a write-one-to-clear in the same cycle
  logic [3:0] set_ev;
  logic [3:0] clr_ev;
  assign set_ev = {abort_req,
                   (state == FCR_ARB) && arr_busy[cur_bank] && !cur_pf,
                   fill && (|dbe_w), fill && (|sbe_w)};
  assign clr_ev = (reg_wr && reg_addr == REG_STATUS) ? reg_wdata[3:0]
                                                     : 4'h0;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sticky   <= 4'h0;
      ecc_addr <= '0;
    end else begin
      sticky <= (sticky & ~clr_ev) | set_ev;
      if (set_ev[ST_SBE] || set_ev[ST_DBE]) begin
        ecc_addr <= cur_addr;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:      reg_rdata <= {27'h0, ctrl};
        REG_TIM0:      reg_rdata <= {28'h0, tim0};
        REG_TIM1:      reg_rdata <= {28'h0, tim1};
        REG_RGN_BASE:  reg_rdata <= {11'h0, rgn_base, 4'h0};
        REG_RGN_LIMIT: reg_rdata <= {11'h0, rgn_limit, 4'h0};
        REG_RGN_TIM:   reg_rdata <= {27'h0, rgn_tim};
        REG_STATUS:    reg_rdata <= {26'h0, arr_busy, sticky};
        REG_ECC_ADDR:  reg_rdata <= {10'h0, ecc_addr};
        default:       reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule : fcr_ctrl

`default_nettype wire

// *** fcr_ctrl_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcr_ctrl_asserts (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [1:0]  arr_rd_en,
  input wire logic [1:0]  arr_wr_en,
  input wire logic [1:0]  arr_busy,
  input wire logic [1:0]  arr_abort,
  input wire logic        stall_note
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic bad_wr = hsel && hready && htrans[1] && hwrite
                      && (hsize != 3'h2 || haddr[1:0] != 2'h0);
  sequence s_err;
    !hreadyout && hresp ##1 hreadyout && hresp;
  endsequence
  sequence s_fill;
    !hreadyout [*2];
  endsequence
  chk_err_resp: assert property ($rose(hresp) |-> s_err)
    else $error("error response shape wrong");
  chk_bad_wr: assert property (bad_wr |-> ##2 (arr_wr_en == 2'h0) [*2])
    else $error("refused write reached the array");
  chk_data_miss: assert property (arr_rd_en[1] |-> s_fill)
    else $error("data bank read without demand miss");
  chk_rd_pulse: assert property (arr_rd_en != 2'h0 |=> arr_rd_en == 2'h0)
    else $error("array read strobe too long");
  chk_miss_bound: assert property ($fell(hreadyout) && arr_busy == 2'h0
    |-> ##[1:40] hreadyout)
    else $error("wait states without bound");
  chk_abort_pulse: assert property (arr_abort != 2'h0 |=> arr_abort == 2'h0)
    else $error("abort longer than one cycle");
  chk_abort_cause: assert property (arr_abort != 2'h0 |-> $past(arr_busy) != 2'h0)
    else $error("abort with idle array");
  chk_stall_cause: assert property (stall_note |-> $past(arr_busy) != 2'h0)
    else $error("stall notice with idle array");
endmodule : fcr_ctrl_asserts
bind fcr_ctrl fcr_ctrl_asserts u_chk (.*);
`default_nettype wire

// *** fcr_array_model.sv ***
`timescale 1ns/1ns
`default_nettype none
package fcr_tb_pkg;
  function automatic logic [63:0] word_of(input logic b, input logic [16:0] p,
                                          input logic h);
    return {p, 14'h2a5a, b, h, ~p, 14'h0c3d};
  endfunction : word_of
  function automatic logic [7:0] chk_of(input logic [63:0] v);
    logic [6:0] s;
    int         q;
    s = 7'h0;
    q = 3;
    for (int i = 0; i < 64; i++) begin
      while ((q & (q - 1)) == 0) q++;
      if (v[i]) s ^= q[6:0];
      q++;
    end
    return {^{v, s}, s};
  endfunction : chk_of
  // Faults hit the stored data only, so the check bits stay clean
  function automatic logic [143:0] line_of(input logic b, input logic [16:0] p,
                                           input logic [63:0] f);
    logic [63:0] lo;
    logic [63:0] hi;
    lo = word_of(b, p, 1'b0);
    hi = word_of(b, p, 1'b1);
    return {chk_of(hi), chk_of(lo), hi, lo ^ f};
  endfunction : line_of
endpackage : fcr_tb_pkg

module fcr_array_model import fcr_pkg::*, fcr_tb_pkg::*; (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic [1:0]        arr_rd_en,
  input  wire logic [PAGE_W-1:0] arr_rd_page,
  input  wire logic [1:0]        arr_abort,
  input  wire logic [1:0]        busy_go,
  input  wire logic [1:0]        flip,
  output logic      [RAW_W-1:0]  arr_rdata0,
  output logic      [RAW_W-1:0]  arr_rdata1,
  output logic      [1:0]        arr_busy
);
  logic [1:0][PAGE_W-1:0] pg;
  logic [1:0][3:0]        bcnt;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg <= '0;
      bcnt <= '0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (arr_rd_en[b]) pg[b] <= arr_rd_page;
        if (busy_go[b]) bcnt[b] <= 4'h8;
        else if (arr_abort[b]) bcnt[b] <= 4'h0;
        else if (bcnt[b] != 4'h0) bcnt[b] <= bcnt[b] - 4'h1;
      end
    end
  end
  assign arr_busy = {bcnt[1] != 4'h0, bcnt[0] != 4'h0};
  // A one-cycle access takes its line in the cycle of the strobe
  assign arr_rdata0 = line_of(1'b0, arr_rd_en[0] ? arr_rd_page : pg[0],
                              64'h0);
  assign arr_rdata1 = line_of(1'b1, arr_rd_en[1] ? arr_rd_page : pg[1],
                              {54'h0, flip[1], 3'h0, |flip, 5'h0});
endmodule : fcr_array_model
`default_nettype wire

// *** fcr_ctrl_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcr_ctrl_test import fcr_pkg::*, fcr_tb_pkg::*;;
  logic core_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, er;
  logic reg_wr, reg_rd, arr_wr_hi, stall_note, abort_note, ecc_sbe, ecc_dbe;
  logic [1:0] htrans, arr_rd_en, arr_wr_en, arr_busy, arr_abort, busy_go, flip;
  logic [31:0] haddr, reg_wdata, reg_rdata, r, a;
  logic [63:0] hwdata, hrdata, arr_wr_data, d;
  logic [2:0] hsize, sz;
  logic [7:0] reg_addr;
  logic [PAGE_W-1:0] arr_rd_page;
  logic [RAW_W-1:0] arr_rdata0, arr_rdata1;
  logic [20:3] arr_wr_addr;
  logic [15:0] lfsr = 16'ha546;
  int error_cnt, tests_run, cyc, ws;
  logic [23:0] ev;
  logic [52:0] wa;
  always @(negedge core_clk) begin
    ev <= !reset_n ? 24'h0 : ev + {4'(|arr_abort), 4'(abort_note),
      4'(stall_note), 4'(ecc_dbe), 4'(ecc_sbe), 4'(|arr_wr_en)};
    if (|arr_wr_en) wa <= {arr_wr_en, arr_wr_hi, arr_wr_addr,
                           arr_wr_data[31:0]};
  end
  // Single slave on the bus, so it sees its own ready
  assign hready = hreadyout;
  fcr_ctrl dut (.*);
  fcr_array_model u_arr (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask : cmp
  function automatic logic [31:0] ad(input logic b, input int p, input logic h);
    return {10'h0, b, p[16:0], h, 3'h0};
  endfunction : ad
  task automatic ahb(input logic w, input logic [2:0] s, input logic [31:0] x,
                     input logic [63:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= x;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    // Address stands until the slave is ready at the sampling edge
    @(negedge core_clk);
    while (hreadyout !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ws = 0;
    @(negedge core_clk);
    while (hreadyout !== 1'b1 && ws < 40) begin
      ws++;
      @(negedge core_clk);
    end
    d = hrdata;
    er = hresp;
  endtask : ahb
  // Negative wait count skips the timing check
  task automatic rd(input logic [31:0] x, input int ew);
    ahb(1'b0, 3'h3, x, 64'h0);
    cmp(d, word_of(x[21], x[20:4], x[3]));
    if (ew >= 0) cmp(64'(ws), 64'(ew));
  endtask : rd
  task automatic reg_io(input logic w, input logic [7:0] x, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= x;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge core_clk);
    r = reg_rdata;
  endtask : reg_io
  task automatic chk_reg(input logic [7:0] x, input logic [31:0] e);
    reg_io(1'b0, x, 32'h0);
    cmp(64'(r), 64'(e));
  endtask : chk_reg
  task automatic idle;
    repeat (8) @(posedge core_clk);
  endtask : idle
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : step
  initial begin
    {hsel, hwrite, reg_wr, reg_rd, busy_go, flip} = 8'h0;
    {haddr, htrans, hsize, hwdata, reg_addr, reg_wdata} = '0;
    reset_n = 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    chk_reg(REG_CTRL, 32'(CTRL_RST));
    chk_reg(REG_TIM0, 32'(TIM0_RST));
    chk_reg(REG_TIM1, 32'(TIM1_RST));
    chk_reg(REG_RGN_TIM, 32'(RGN_TIM_RST));
    chk_reg(8'h20, 32'h0);
    rd(ad(0, 'h10, 0), 3);
    idle();
    rd(ad(0, 'h11, 0), 0);
    rd(ad(0, 'h10, 1), 0);
    reg_io(1'b1, REG_CTRL, 32'h1);
    idle();
    rd(ad(1, 'h20, 1), 3);
    rd(ad(1, 'h20, 0), 0);
    idle();
    rd(ad(1, 'h21, 0), 3);
    ahb(1'b1, 3'h1, ad(1, 'h21, 0), 64'h5);
    cmp(64'(er), 64'h1);
    rd(ad(1, 'h21, 1), 0);
    cmp(64'(ev[3:0]), 64'h0);
    ahb(1'b1, 3'h2, ad(1, 'h21, 0), 64'h5);
    cmp(64'(er), 64'h0);
    rd(ad(1, 'h21, 1), 3);
    cmp(64'(wa), 64'({2'b10, 1'b0, 17'h21, 1'b0, 32'h5}));
    for (int i = 0; i < 4; i++) rd(ad(0, 'h40 + i, 0), 3);
    rd(ad(0, 'h40, 0), 0);
    rd(ad(0, 'h44, 0), 3);
    rd(ad(0, 'h40, 0), 0);
    rd(ad(0, 'h41, 0), 3);
    reg_io(1'b1, REG_TIM0, 32'h3);
    rd(ad(0, 'h50, 0), 5);
    rd(ad(1, 'h50, 0), 3);
    reg_io(1'b1, REG_TIM0, 32'h1);
    reg_io(1'b1, REG_RGN_BASE, 32'h600);
    reg_io(1'b1, REG_RGN_LIMIT, 32'h610);
    reg_io(1'b1, REG_RGN_TIM, 32'h12);
    rd(ad(0, 'h61, 0), 4);
    rd(ad(0, 'h62, 0), 3);
    reg_io(1'b1, REG_RGN_TIM, 32'h1);
    repeat (12) begin
      lfsr = step(lfsr);
      sz = {1'b0, lfsr[5] & ~lfsr[4], lfsr[4]};
      a = ad(lfsr[0], 'h70 + lfsr[3:1], lfsr[9]) | 32'(lfsr[8:6] & (3'h7 << sz));
      ahb(1'b0, sz, a, 64'h0);
      cmp(d, word_of(a[21], a[20:4], a[3]));
    end
    ahb(1'b0, 3'h2, ad(0, 'h70, 0) | 32'h2, 64'h0);
    cmp(64'(er), 64'h1);
    reg_io(1'b1, REG_STATUS, 32'hf);
    @(posedge core_clk) flip <= 2'h1;
    rd(ad(1, 'h80, 0), 3);
    chk_reg(REG_STATUS, 32'h1);
    reg_io(1'b1, REG_STATUS, 32'hf);
    @(posedge core_clk) flip <= 2'h2;
    ahb(1'b0, 3'h3, ad(1, 'h81, 0), 64'h0);
    chk_reg(REG_STATUS, 32'h2);
    chk_reg(REG_ECC_ADDR, ad(1, 'h81, 0));
    @(posedge core_clk) flip <= 2'h0;
    reg_io(1'b1, REG_CTRL, 32'h1d);
    reg_io(1'b1, REG_STATUS, 32'hf);
    @(posedge core_clk) busy_go <= 2'h2;
    @(posedge core_clk) busy_go <= 2'h0;
    rd(ad(1, 'h90, 0), -1);
    cmp(64'(ws > 3), 64'h1);
    chk_reg(REG_STATUS, 32'hc);
    cmp(64'(ev[23:4]), 64'h11111);
    reg_io(1'b1, REG_TIM1, 32'h0);
    rd(ad(1, 'h91, 0), 2);
    wrap_up();
  end
endmodule : fcr_ctrl_test
`default_nettype wire
